/* rtl/cbsrl_pkg.sv */
// constants and types for the local-bus strobe, ready and lock logic
// assumes one clock, clk_sys at 100 MHz, and a synchronous reset
// Operation
// - queue status codes: 00 idle, 01 first opcode, 11 next byte, 10 flush.
// - read strobe low in second, third and wait states of a read, else high.
// - read strobe goes low in second state only after address bus floats.
// - during reset read strobe driven high one clock, then floated.
// - weak pull-up keeps read strobe line high when undriven.
// - read strobe pin sampled at reset: high strobe mode, low queue mode.
// - async ready accepted anytime; only its rising edge is synchronised.
// - cycle ends only with a ready input active; otherwise wait states.
// - sync ready tied high gives no wait states.
// - after lock prefix, lock low from first data cycle until instruction ends.
// - no prefetch cycles while lock is asserted.
// - during reset lock driven high one clock, then floated.
// - queue mode puts status on latch-enable and write strobe pins.
// - write strobe low in second, third and wait states; floats in hold.
package cbsrl_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TSTATE_NS = 20;
   localparam int TSTATE_CYC = (TSTATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // bus states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b010,
      ST_T3 = 3'b011,
      ST_TW = 3'b100,
      ST_T4 = 3'b101
   } cbsrl_state_t;

   // ----------------------------------------------------------------
   // queue status codes, {bit1, bit0}
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      QS_NONE = 2'b00,
      QS_FIRST = 2'b01,
      QS_NEXT = 2'b11,
      QS_FLUSH = 2'b10
   } cbsrl_qs_t;

   localparam logic [1:0] QS_RESET = 2'h0;

   // flush outranks fetches
   function automatic cbsrl_qs_t cbsrl_qs_encode(input logic first, input logic next,
                                                 input logic flush);
      cbsrl_qs_t code;
      code = QS_NONE;
      if (flush) begin
         code = QS_FLUSH;
      end else if (first) begin
         code = QS_FIRST;
      end else if (next) begin
         code = QS_NEXT;
      end
      return code;
   endfunction

endpackage

/* rtl/cbsrl_link_if.sv */
// carrier between the bus control core and its ready and queue helpers
// assumes all users run on clk_sys
`timescale 1ns/10ps
`default_nettype none
interface cbsrl_link_if;
   logic ready;
   logic [1:0] qs;

   modport core(input ready, input qs);
   modport rdy(output ready);
   modport qstat(output qs);
endinterface
`default_nettype wire

/* rtl/cbsrl_ready_sync.sv */
// ready combiner: async ready rise synchronised, fall passes straight
// assumes sync ready is already synchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
module cbsrl_ready_sync
   import cbsrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic async_ready_in,
   input wire logic sync_ready_in,
   cbsrl_link_if.rdy link
);

   logic meta_q;
   logic sync_q;

   // ----------------------------------------------------------------
   // two-stage synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_ready_in;
         sync_q <= meta_q;
      end
   end

   // rise delayed, fall immediate
   assign link.ready = (sync_q & async_ready_in) | sync_ready_in;

endmodule
`default_nettype wire

/* rtl/cbsrl_qstat.sv */
// queue status register fed by the instruction queue events
// assumes events are one-cycle pulses on clk_sys
`timescale 1ns/10ps
`default_nettype none
module cbsrl_qstat
   import cbsrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic q_first,
   input wire logic q_next,
   input wire logic q_flush,
   cbsrl_link_if.qstat link
);

   logic [1:0] qs_q;
   logic first_q;
   logic next_q;
   logic flush_q;

   // events gathered over one processor clock
   always_ff @(posedge clk_sys) begin
      if (sys_rst || tick) begin
         first_q <= 1'b0;
         next_q <= 1'b0;
         flush_q <= 1'b0;
      end else begin
         first_q <= first_q | q_first;
         next_q <= next_q | q_next;
         flush_q <= flush_q | q_flush;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         qs_q <= QS_RESET;
      end else if (tick) begin
         qs_q <= cbsrl_qs_encode(first_q | q_first, next_q | q_next, flush_q | q_flush);
      end
   end

   assign link.qs = qs_q;

endmodule
`default_nettype wire

/* rtl/cbsrl_bus_ctrl.sv */
// local-bus control: T-state sequencer, strobes, ready, lock, mode strap
// assumes core requests are pulses on clk_sys; pins resolved outside
`timescale 1ns/10ps
`default_nettype none
module cbsrl_bus_ctrl
   import cbsrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic cycle_req,
   input wire logic cycle_read,
   input wire logic cycle_prefetch,
   output logic cycle_accept,
   output logic cycle_done,
   input wire logic lock_prefix,
   input wire logic instr_done,
   input wire logic hold_active,
   input wire logic q_first,
   input wire logic q_next,
   input wire logic q_flush,
   input wire logic async_ready_in,
   input wire logic sync_ready_in,
   input wire logic read_strobe_or_qmode_select_in,
   output logic read_strobe_or_qmode_select_o,
   output logic read_strobe_or_qmode_select_oe_n,
   output logic read_pullup_en,
   output logic ale_or_queue_status_bit0_o,
   output logic write_or_queue_status_bit1_o,
   output logic write_or_queue_status_bit1_oe_n,
   output logic lock_n_o,
   output logic lock_oe_n,
   output logic addr_oe_n,
   output logic qmode_o
);

   cbsrl_link_if link ();

   cbsrl_state_t state_q;
   logic [$clog2(TSTATE_CYC+1)-1:0] div_q;
   logic tick;
   logic rst_seen_q;
   logic qmode_q;
   logic read_q;
   logic addr_oe_n_q;
   logic rd_n_q;
   logic wr_n_q;
   logic ale_q;
   logic lock_arm_q;
   logic lock_act_q;
   logic done_q;
   logic data_phase;
   logic ending;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   cbsrl_ready_sync u_rdy (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_ready_in(async_ready_in),
      .sync_ready_in(sync_ready_in),
      .link(link.rdy)
   );

   cbsrl_qstat u_qs (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .tick(tick),
      .q_first(q_first),
      .q_next(q_next),
      .q_flush(q_flush),
      .link(link.qstat)
   );

   // ----------------------------------------------------------------
   // processor clock enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   assign tick = (div_q == ($clog2(TSTATE_CYC+1))'(TSTATE_CYC - 1));

   // ----------------------------------------------------------------
   // reset drive window and mode strap
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      rst_seen_q <= sys_rst;
   end

   // pin is released after the first reset clock, then sampled
   always_ff @(posedge clk_sys) begin
      if (sys_rst && rst_seen_q) begin
         qmode_q <= ~read_strobe_or_qmode_select_in;
      end
   end

   // ----------------------------------------------------------------
   // request acceptance
   // ----------------------------------------------------------------
   always_comb begin
      cycle_accept = !sys_rst && !hold_active && (state_q == ST_IDLE) && tick;
      if (cycle_prefetch && (lock_act_q || lock_arm_q)) begin
         cycle_accept = 1'b0;
      end
   end

   assign data_phase = (state_q == ST_T2) || (state_q == ST_T3) || (state_q == ST_TW);
   // last clk of T3 or wait state with ready: strobes rise with T4
   assign ending = tick && ((state_q == ST_T3) || (state_q == ST_TW)) && link.ready;

   // ----------------------------------------------------------------
   // T-state sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else if (tick) begin
         case (state_q)
            ST_IDLE: begin
               if (cycle_req && cycle_accept) begin
                  state_q <= ST_T1;
               end
            end
            ST_T1: begin
               state_q <= ST_T2;
            end
            ST_T2: begin
               state_q <= ST_T3;
            end
            ST_T3, ST_TW: begin
               if (link.ready) begin
                  state_q <= ST_T4;
               end else begin
                  state_q <= ST_TW;
               end
            end
            ST_T4: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         read_q <= 1'b0;
      end else if (tick && cycle_req && cycle_accept) begin
         read_q <= cycle_read;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= tick && (state_q == ST_T4);
      end
   end

   assign cycle_done = done_q;

   // ----------------------------------------------------------------
   // address float and strobes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         addr_oe_n_q <= 1'b1;
      end else begin
         addr_oe_n_q <= hold_active || (state_q != ST_T1) || (read_q && tick);
      end
   end

   // strobe falls one clk after the address has floated
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_n_q <= 1'b1;
      end else begin
         rd_n_q <= !(read_q && data_phase && addr_oe_n_q && !ending);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_n_q <= 1'b1;
      end else begin
         wr_n_q <= !(!read_q && (data_phase || ((state_q == ST_T1) && tick)) && !ending);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ale_q <= 1'b0;
      end else begin
         ale_q <= (state_q == ST_T1) && !tick;
      end
   end

   // ----------------------------------------------------------------
   // bus lock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         lock_arm_q <= 1'b0;
         lock_act_q <= 1'b0;
      end else begin
         if (lock_prefix) begin
            lock_arm_q <= 1'b1;
         end else if (lock_arm_q && tick && cycle_req && cycle_accept && !cycle_prefetch) begin
            lock_arm_q <= 1'b0;
         end
         if (lock_arm_q && tick && cycle_req && cycle_accept && !cycle_prefetch) begin
            lock_act_q <= 1'b1;
         end else if (instr_done && !lock_arm_q) begin
            lock_act_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   assign read_pullup_en = 1'b1;
   assign addr_oe_n = addr_oe_n_q;
   assign qmode_o = qmode_q;

   always_comb begin
      read_strobe_or_qmode_select_o = 1'b1;
      write_or_queue_status_bit1_o = 1'b1;
      lock_n_o = 1'b1;
      ale_or_queue_status_bit0_o = 1'b0;
      if (sys_rst) begin
         read_strobe_or_qmode_select_oe_n = rst_seen_q;
         write_or_queue_status_bit1_oe_n = rst_seen_q;
         lock_oe_n = rst_seen_q;
      end else begin
         // grounded pin in queue mode is not driven outside the first reset clock
         read_strobe_or_qmode_select_oe_n = hold_active || qmode_q;
         read_strobe_or_qmode_select_o = rd_n_q;
         lock_oe_n = 1'b0;
         lock_n_o = !lock_act_q;
         if (qmode_q) begin
            write_or_queue_status_bit1_oe_n = 1'b0;
            write_or_queue_status_bit1_o = link.qs[1];
            ale_or_queue_status_bit0_o = link.qs[0];
         end else begin
            write_or_queue_status_bit1_oe_n = hold_active;
            write_or_queue_status_bit1_o = wr_n_q;
            ale_or_queue_status_bit0_o = ale_q;
         end
      end
   end

endmodule
`default_nettype wire

/* bench/cbsrl_bus_checker.sv */
// port assertions for the bus control block
// assumes one clock, clk_sys, and synchronous sys_rst
`timescale 1ns/10ps
`default_nettype none
module cbsrl_bus_checker (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic cycle_req,
   input wire logic cycle_accept,
   input wire logic cycle_prefetch,
   input wire logic cycle_done,
   input wire logic lock_prefix,
   input wire logic instr_done,
   input wire logic async_ready_in,
   input wire logic sync_ready_in,
   input wire logic read_strobe_or_qmode_select_o,
   input wire logic read_strobe_or_qmode_select_oe_n,
   input wire logic write_or_queue_status_bit1_o,
   input wire logic lock_n_o,
   input wire logic lock_oe_n,
   input wire logic addr_oe_n,
   input wire logic qmode_o
);
   logic arm_q;
   wire take = cycle_req && cycle_accept;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // lock armed by prefix until its data cycle is taken
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         arm_q <= 1'h0;
      end else if (lock_prefix) begin
         arm_q <= 1'h1;
      end else if (take && !cycle_prefetch) begin
         arm_q <= 1'h0;
      end
   end
   property p_rd_float;
      $fell(read_strobe_or_qmode_select_o) |-> addr_oe_n;
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("read strobe fell before float");
   property p_rd_idle;
      !qmode_o && cycle_done |-> read_strobe_or_qmode_select_o && write_or_queue_status_bit1_o;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("strobe low after cycle");
   property p_no_wait;
      take && sync_ready_in ##1 sync_ready_in [*8] |=> cycle_done;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("wait state with ready high");
   property p_needs_rdy;
      take ##1 (!sync_ready_in && !async_ready_in) [*8] |=> !cycle_done;
   endproperty
   a_needs_rdy: assert property (p_needs_rdy) else $error("cycle ended without ready");
   property p_lock_on;
      arm_q && take && !cycle_prefetch |=> !lock_n_o;
   endproperty
   a_lock_on: assert property (p_lock_on) else $error("lock not asserted");
   property p_lock_off;
      instr_done && !lock_prefix && !lock_n_o |=> lock_n_o;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock not released");
   property p_no_prefetch;
      cycle_accept && cycle_prefetch |-> lock_n_o && !arm_q;
   endproperty
   a_no_prefetch: assert property (p_no_prefetch) else $error("prefetch under lock");
   property p_rst_float;
      disable iff (1'b0) sys_rst [*3] |-> read_strobe_or_qmode_select_oe_n && lock_oe_n;
   endproperty
   a_rst_float: assert property (p_rst_float) else $error("pins driven in reset");
endmodule
bind cbsrl_bus_ctrl cbsrl_bus_checker chk_u (.clk_sys, .sys_rst, .cycle_req, .cycle_accept,
   .cycle_prefetch, .cycle_done, .lock_prefix, .instr_done, .async_ready_in, .sync_ready_in,
   .read_strobe_or_qmode_select_o, .read_strobe_or_qmode_select_oe_n,
   .write_or_queue_status_bit1_o, .lock_n_o, .lock_oe_n, .addr_oe_n, .qmode_o);
`default_nettype wire

/* bench/cbsrl_mem_model.sv */
// ready source and read pin standing in for memory and io
// assumes the bench sets ready kind and wait count between cycles
`timescale 1ns/10ps
`default_nettype none
module cbsrl_mem_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic use_sync,
   input wire logic [3:0] wait_n,
   input wire logic grounded,
   input wire logic addr_oe_n,
   input wire logic cycle_done,
   input wire logic rd_o,
   input wire logic rd_oe_n,
   input wire logic pullup_en,
   output logic async_ready_in,
   output logic sync_ready_in,
   output logic rd_pin
);
   logic busy_q;
   logic rdy_q;
   logic [3:0] cnt_q;
   always_ff @(posedge clk_sys) begin
      if (sys_rst || cycle_done) begin
         busy_q <= 1'h0;
         rdy_q <= 1'h0;
         cnt_q <= 4'h0;
      end else if (busy_q || !addr_oe_n) begin
         busy_q <= 1'h1;
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == wait_n) begin
            rdy_q <= 1'h1; // edges only on the clock
         end
      end
   end
   assign async_ready_in = !use_sync && rdy_q;
   assign sync_ready_in = use_sync && (rdy_q || wait_n == 4'h0);
   assign rd_pin = !rd_oe_n ? rd_o : (!grounded && pullup_en);
endmodule
`default_nettype wire

/* bench/cpu_bus_strobe_ready_lock_bench.sv */
// self-checking bench for the bus control block
// assumes the checker and the memory model are compiled first
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_strobe_ready_lock_bench;
   logic clk_sys = 1'h0, sys_rst = 1'h1, req = 1'h0, rd = 1'h0, pf = 1'h0, lk = 1'h0;
   logic idn = 1'h0, hold = 1'h0, use_sync = 1'h1, gnd = 1'h0;
   logic [2:0] qev = 3'h0;
   logic [3:0] wn = 4'h0;
   wire acc, done, ard, srd, pin, rdo, rdoe, pu, ale, wro, wroe, lkn, lkoe, aoe, qm;
   int err_total = 0, check_count = 0, cyc = 0;
   cbsrl_bus_ctrl dut_u (.clk_sys, .sys_rst, .cycle_req(req), .cycle_read(rd),
      .cycle_prefetch(pf), .cycle_accept(acc), .cycle_done(done), .lock_prefix(lk),
      .instr_done(idn), .hold_active(hold), .q_first(qev[0]), .q_next(qev[1]),
      .q_flush(qev[2]), .async_ready_in(ard), .sync_ready_in(srd),
      .read_strobe_or_qmode_select_in(pin), .read_strobe_or_qmode_select_o(rdo),
      .read_strobe_or_qmode_select_oe_n(rdoe), .read_pullup_en(pu),
      .ale_or_queue_status_bit0_o(ale), .write_or_queue_status_bit1_o(wro),
      .write_or_queue_status_bit1_oe_n(wroe), .lock_n_o(lkn), .lock_oe_n(lkoe),
      .addr_oe_n(aoe), .qmode_o(qm));
   cbsrl_mem_model mem_u (.clk_sys, .sys_rst, .use_sync, .wait_n(wn), .grounded(gnd),
      .addr_oe_n(aoe), .cycle_done(done), .rd_o(rdo), .rd_oe_n(rdoe), .pullup_en(pu),
      .async_ready_in(ard), .sync_ready_in(srd), .rd_pin(pin));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done;
      end
   end
   task automatic do_rst(input logic g);
      @(posedge clk_sys);
      gnd <= g;
      sys_rst <= 1'h1;
      repeat (4) @(posedge clk_sys);
      #1 chk("rst_oe", {rdoe, lkoe}, 8'h3);
      @(posedge clk_sys);
      sys_rst <= 1'h0;
      @(negedge clk_sys);
      chk("qmode", qm, g);
   endtask
   // k is clocks from take to done, 0 when refused; lo flags {ale high, write, read low}
   task automatic run(input logic r, input logic p, output int k, output logic [2:0] lo);
      logic a;
      k = 0;
      lo = 3'h0;
      a = 1'h0;
      @(posedge clk_sys);
      req <= 1'h1;
      rd <= r;
      pf <= p;
      for (int i = 0; i < 12 && !a; i++) begin
         @(negedge clk_sys);
         a = (acc === 1'h1);
      end
      @(posedge clk_sys);
      req <= 1'h0;
      while (a && k < 40 && done !== 1'h1) begin
         @(negedge clk_sys);
         k++;
         lo |= {ale === 1'h1, wro === 1'h0, pin === 1'h0};
      end
   endtask
   task automatic t_plain;
      int k;
      logic [2:0] lo;
      run(1'h1, 1'h0, k, lo);
      chk("rd_len", 8'(k), 8'd9);
      chk("rd_low", lo, 8'h5);
      run(1'h0, 1'h0, k, lo);
      chk("wr_len", 8'(k), 8'd9);
      chk("wr_low", lo, 8'h6);
      $display("test plain done");
   endtask
   task automatic t_wait;
      int k;
      logic [2:0] lo;
      for (int s = 0; s < 2; s++) begin
         use_sync <= s[0];
         wn <= 4'h5;
         run(1'h1, 1'h0, k, lo);
         chk("wait_len", k > 9 && k < 30 && k % 2 == 1, 8'h1);
      end
      wn <= 4'h0;
      use_sync <= 1'h1;
      $display("test wait done");
   endtask
   task automatic t_lock;
      int k;
      logic [2:0] lo;
      @(posedge clk_sys);
      lk <= 1'h1;
      @(posedge clk_sys);
      lk <= 1'h0;
      run(1'h1, 1'h1, k, lo);
      chk("pf_armed", 8'(k), 8'd0);
      run(1'h0, 1'h0, k, lo);
      chk("lock_on", lkn, 8'h0);
      run(1'h1, 1'h1, k, lo);
      chk("pf_locked", 8'(k), 8'd0);
      @(posedge clk_sys);
      idn <= 1'h1;
      @(posedge clk_sys);
      idn <= 1'h0;
      @(negedge clk_sys);
      chk("lock_off", lkn, 8'h1);
      run(1'h1, 1'h1, k, lo);
      chk("pf_free", 8'(k), 8'd9);
      $display("test lock done");
   endtask
   task automatic t_hold;
      int k;
      logic [2:0] lo;
      @(posedge clk_sys);
      hold <= 1'h1;
      repeat (3) @(negedge clk_sys);
      chk("hold_rd", {rdoe, pin}, 8'h3);
      chk("hold_wr", wroe, 8'h1);
      run(1'h1, 1'h0, k, lo);
      chk("hold_req", 8'(k), 8'd0);
      hold <= 1'h0;
      $display("test hold done");
   endtask
   task automatic t_queue;
      logic [2:0] ev [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
      logic [1:0] cd [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
      do_rst(1'h1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         qev <= ev[i];
         repeat (2) @(posedge clk_sys);
         qev <= 3'h0;
         repeat (2) @(negedge clk_sys);
         chk("qs", {wro, ale}, cd[i]);
      end
      $display("test queue done");
   endtask
   initial begin
      do_rst(1'h0);
      t_plain;
      t_wait;
      t_lock;
      t_hold;
      t_queue;
      test_done;
   end
endmodule
`default_nettype wire
